// ---- pkg/p1sd_pkg.sv ----
`default_nettype none

package p1sd_pkg;

  // Tie-off defaults used when no strap value is supplied.
  localparam logic STRAP_RATE_DEFAULT = 1'h1;
  localparam logic STRAP_DUPLEX_DEFAULT = 1'h1;
  localparam logic STRAP_BACKPRESSURE_DEFAULT = 1'h1;
  localparam logic STRAP_PAUSE_DEFAULT = 1'h1;

  // Field positions of the bits seeded by the straps.
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_10HD_BIT = 5;
  localparam int MODE_WIDTH = 3;

  // Special mode encodings chosen from rate and duplex with autonegotiation off.
  localparam logic [2:0] MODE_10HD = 3'h0;
  localparam logic [2:0] MODE_10FD = 3'h1;
  localparam logic [2:0] MODE_100HD = 3'h2;
  localparam logic [2:0] MODE_100FD = 3'h3;

  // Strap vector layout: rate, duplex, backpressure, pause.
  localparam int STRAP_W = 4;
  localparam int S_RATE = 0;
  localparam int S_DUPLEX = 1;
  localparam int S_BP = 2;
  localparam int S_PAUSE = 3;
  localparam logic [3:0] STRAP_RESET_VALUE = 4'hF;

endpackage : p1sd_pkg

`default_nettype wire

// ---- pkg/p1sd_strap_if.sv ----
`default_nettype none

// Carries the effective strap vector from the latch to the default decoder.
interface p1sd_strap_if;
  import p1sd_pkg::*;
  logic [STRAP_W-1:0] eff; // Effective strap values.
  logic load; // Pulse: reload register defaults from eff.
  modport src (output eff, output load);
  modport dst (input eff, input load);
endinterface : p1sd_strap_if

`default_nettype wire

// ---- design/p1sd_strap_latch.sv ----
`default_nettype none

// Holds the pin-latched straps and the effective (possibly overridden) straps.
module p1sd_strap_latch
  import p1sd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hard_reset_release,
  input wire logic [STRAP_W-1:0] strap_pins,
  input wire logic eeprom_load,
  input wire logic [STRAP_W-1:0] eeprom_values,
  input wire logic revert,
  p1sd_strap_if.src sif
);

  logic [STRAP_W-1:0] latched; // Values sampled at the last hard reset release.
  logic [STRAP_W-1:0] eff; // Values in force.
  logic load; // Reload pulse.

  // Named selection of the next effective value; the loader wins over revert.
  wire [STRAP_W-1:0] next_eff = hard_reset_release ? strap_pins :
                                eeprom_load ? eeprom_values :
                                revert ? latched : eff;
  wire next_load = hard_reset_release | eeprom_load | revert;

  // Pins are sampled only on hard reset release, never on revert.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      latched <= STRAP_RESET_VALUE;
    end
    else if (hard_reset_release)
    begin
      latched <= strap_pins;
    end
  end

  // The effective set follows the loader or falls back to the latched set.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      eff <= STRAP_RESET_VALUE;
      load <= 1'h0;
    end
    else
    begin
      eff <= next_eff;
      load <= next_load;
    end
  end

  assign sif.eff = eff;
  assign sif.load = load;

  revert_uses_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    revert && !eeprom_load && !hard_reset_release |=> eff == $past(latched))
    else $error("Revert did not restore latched straps.");

  pins_not_resampled_a: assert property (@(posedge clk_sys) disable iff (rst)
    !hard_reset_release |=> latched == $past(latched))
    else $error("Strap pins were sampled outside a hard reset release.");

endmodule : p1sd_strap_latch

`default_nettype wire

// ---- design/p1sd_top.sv ----
// What this block does
// - Rate strap seeds rate select bit.
// - Rate strap shapes advertisement bits and mode.
// - Duplex strap seeds duplex select bit.
// - Duplex strap shapes 10FD advertise and mode.
// - Backpressure strap seeds backpressure enable.
// - Pause strap seeds transmit and receive pause.
// - Capture straps at hard reset; loader overrides.
// - Digital reset reverts to latched, no resampling.
`default_nettype none

module p1sd_top
  import p1sd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin_reset_n,
  input wire logic power_on_reset,
  input wire logic port1_rate_default_pin,
  input wire logic port1_duplex_default_pin,
  input wire logic port1_backpressure_default_pin,
  input wire logic port1_pause_default_pin,
  input wire logic eeprom_load,
  input wire logic [STRAP_W-1:0] eeprom_values,
  input wire logic digital_reset,
  input wire logic sw_write,
  input wire logic [7:0] sw_data,
  output logic rate_select_low_bit,
  output logic duplex_select_bit,
  output logic adv_10_full,
  output logic adv_10_half,
  output logic [MODE_WIDTH-1:0] phy_special_mode,
  output logic port1_backpressure_enable,
  output logic port1_pause_transmit_enable,
  output logic port1_pause_receive_enable
);

  // Hard reset is either reset source; its release is the cycle it drops.
  logic hard_reset_q; // Hard reset seen on the previous cycle.
  wire hard_reset = power_on_reset | ~pin_reset_n;
  wire hard_reset_release = hard_reset_q & ~hard_reset;

  // Straps gathered into the vector the latch expects.
  wire [STRAP_W-1:0] strap_pins = {port1_pause_default_pin, port1_backpressure_default_pin,
                                   port1_duplex_default_pin, port1_rate_default_pin};

  p1sd_strap_if sif ();

  // Reset release is caught by a clocked process, never by the reset itself.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hard_reset_q <= 1'h0;
    end
    else
    begin
      hard_reset_q <= hard_reset;
    end
  end

  p1sd_strap_latch u_latch (
    .clk_sys(clk_sys),
    .rst(rst),
    .hard_reset_release(hard_reset_release),
    .strap_pins(strap_pins),
    .eeprom_load(eeprom_load),
    .eeprom_values(eeprom_values),
    .revert(digital_reset),
    .sif(sif)
  );

  // Decoded defaults from the effective straps.
  wire d_rate = sif.eff[S_RATE];
  wire d_duplex = sif.eff[S_DUPLEX];
  wire [MODE_WIDTH-1:0] d_mode = d_rate ? (d_duplex ? MODE_100FD : MODE_100HD) :
                                          (d_duplex ? MODE_10FD : MODE_10HD);
  wire d_adv_10fd = ~d_rate & d_duplex;
  wire d_adv_10hd = ~d_rate;

  // Software write image; a load pulse takes priority so defaults always land.
  wire [7:0] reg_image = {rate_select_low_bit, duplex_select_bit, adv_10_full, adv_10_half,
                          port1_backpressure_enable, port1_pause_transmit_enable,
                          port1_pause_receive_enable, 1'h0};
  wire [7:0] default_image = {d_rate, d_duplex, d_adv_10fd, d_adv_10hd,
                              sif.eff[S_BP], sif.eff[S_PAUSE], sif.eff[S_PAUSE], 1'h0};
  wire [7:0] next_image = sif.load ? default_image : sw_write ? sw_data : reg_image;
  wire [MODE_WIDTH-1:0] next_mode = sif.load ? d_mode : phy_special_mode;

  // Register bits; defaults after reset match the tie-off strap values.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rate_select_low_bit <= STRAP_RATE_DEFAULT;
      duplex_select_bit <= STRAP_DUPLEX_DEFAULT;
      adv_10_full <= 1'h0;
      adv_10_half <= 1'h0;
      phy_special_mode <= MODE_100FD;
      port1_backpressure_enable <= STRAP_BACKPRESSURE_DEFAULT;
      port1_pause_transmit_enable <= STRAP_PAUSE_DEFAULT;
      port1_pause_receive_enable <= STRAP_PAUSE_DEFAULT;
    end
    else
    begin
      rate_select_low_bit <= next_image[7];
      duplex_select_bit <= next_image[6];
      adv_10_full <= next_image[5];
      adv_10_half <= next_image[4];
      port1_backpressure_enable <= next_image[3];
      port1_pause_transmit_enable <= next_image[2];
      port1_pause_receive_enable <= next_image[1];
      phy_special_mode <= next_mode;
    end
  end

  rate_default_a: assert property (@(posedge clk_sys) disable iff (rst)
    sif.load |=> rate_select_low_bit == $past(sif.eff[S_RATE]))
    else $error("Rate bit missed its default.");
  duplex_default_a: assert property (@(posedge clk_sys) disable iff (rst)
    sif.load |=> duplex_select_bit == $past(sif.eff[S_DUPLEX]))
    else $error("Duplex bit missed its default.");
  adv_shape_a: assert property (@(posedge clk_sys) disable iff (rst)
    sif.load |=> adv_10_half == !$past(d_rate) && adv_10_full == ($past(d_duplex) && !$past(d_rate)))
    else $error("Advertisement bits wrong.");
  mode_shape_a: assert property (@(posedge clk_sys) disable iff (rst)
    sif.load |=> phy_special_mode == {1'h0, $past(d_rate), $past(d_duplex)})
    else $error("Mode field wrong.");
  bp_default_a: assert property (@(posedge clk_sys) disable iff (rst)
    sif.load |=> port1_backpressure_enable == $past(sif.eff[S_BP]))
    else $error("Backpressure default wrong.");
  pause_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    sif.load |=> port1_pause_transmit_enable == $past(sif.eff[S_PAUSE])
      && port1_pause_receive_enable == $past(sif.eff[S_PAUSE]))
    else $error("Pause defaults wrong.");
  capture_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    hard_reset_release |=> ##1 rate_select_low_bit == $past(port1_rate_default_pin, 2))
    else $error("Strap not captured at release.");
  sw_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
    sw_write && !sif.load |=> port1_backpressure_enable == $past(sw_data[3]))
    else $error("Software write lost.");

endmodule : p1sd_top

`default_nettype wire

// ---- tb/p1sd_strap_model.sv ----
`default_nettype none

// Far side: strap resistors on the four pins and the configuration loader.
module p1sd_strap_model
(
  input wire logic clk_sys,
  input wire logic fitted,
  input wire logic [3:0] level,
  input wire logic e2p_req,
  input wire logic [3:0] e2p_data,
  output logic [3:0] pins,
  output logic eeprom_load,
  output logic [3:0] eeprom_values
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unfitted pins fall to the internal pull-ups, so they read as ones.
  assign pins = fitted ? level : 4'hF;
  initial
  begin
    eeprom_load = 1'h0;
    eeprom_values = 4'h0;
  end
  // Loader issues a one-cycle load; between loads the data lines wander, so stale values never look valid.
  always @(posedge clk_sys)
  begin
    eeprom_load <= e2p_req;
    eeprom_values <= e2p_req ? e2p_data : ~eeprom_values;
  end
endmodule : p1sd_strap_model

`default_nettype wire

// ---- tb/port1_link_strap_defaults_tb.sv ----
`default_nettype none

module port1_link_strap_defaults_tb;
  import p1sd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, rst = 1'h1, pin_reset_n = 1'h1, power_on_reset = 1'h0; // Clock and resets.
  logic fitted = 1'h1, e2p_req = 1'h0, digital_reset = 1'h0, sw_write = 1'h0; // Stimulus controls.
  logic [3:0] level = 4'hF, e2p_data = 4'h0, pins, eeprom_values; // Strap and loader data.
  logic eeprom_load;
  logic [7:0] sw_data = 8'h00; // Software write image.
  logic rate, dup, fd, hd, bp, txp, rxp; // Observed outputs.
  logic [2:0] mode;
  int fails = 0, n_tests = 0;
  wire logic [9:0] seen = {rate, dup, fd, hd, mode, bp, txp, rxp}; // Packed view of all outputs.
  // Clock at 10 MHz.
  always #50 clk_sys = ~clk_sys;
  p1sd_strap_model part_u (.clk_sys(clk_sys), .fitted(fitted), .level(level), .e2p_req(e2p_req),
    .e2p_data(e2p_data), .pins(pins), .eeprom_load(eeprom_load), .eeprom_values(eeprom_values));
  p1sd_top dut_u (.clk_sys(clk_sys), .rst(rst), .pin_reset_n(pin_reset_n), .power_on_reset(power_on_reset),
    .port1_rate_default_pin(pins[S_RATE]), .port1_duplex_default_pin(pins[S_DUPLEX]),
    .port1_backpressure_default_pin(pins[S_BP]), .port1_pause_default_pin(pins[S_PAUSE]),
    .eeprom_load(eeprom_load), .eeprom_values(eeprom_values), .digital_reset(digital_reset),
    .sw_write(sw_write), .sw_data(sw_data), .rate_select_low_bit(rate), .duplex_select_bit(dup),
    .adv_10_full(fd), .adv_10_half(hd), .phy_special_mode(mode), .port1_backpressure_enable(bp),
    .port1_pause_transmit_enable(txp), .port1_pause_receive_enable(rxp));
  // Expected outputs for a strap vector; mode is {0, rate, duplex}.
  function automatic logic [9:0] exp_of(input logic [3:0] s);
    exp_of = {s[S_RATE], s[S_DUPLEX], ~s[S_RATE] & s[S_DUPLEX], ~s[S_RATE], 1'h0, s[S_RATE], s[S_DUPLEX],
      s[S_BP], s[S_PAUSE], s[S_PAUSE]};
  endfunction : exp_of
  // Inputs always move 1 ns after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // Every strap combination, captured alternately by pin reset and power-on reset.
  task automatic t_capture();
    for (int i = 0; i < 16; i++)
    begin
      // The last pass leaves the pins open with low levels, so only the pull-ups can give ones.
      level = (i == 15) ? 4'h0 : 4'(i);
      fitted = (i != 15);
      if (i[0])
        power_on_reset = 1'h1;
      else
        pin_reset_n = 1'h0;
      step(2);
      power_on_reset = 1'h0;
      pin_reset_n = 1'h1;
      step(3);
      chk("captured straps", exp_of(4'(i)));
    end
    fitted = 1'h1;
  endtask : t_capture
  // Loader overrides, even with a revert in the same cycle.
  task automatic t_loader(input logic [3:0] v);
    e2p_data = v;
    e2p_req = 1'h1;
    step(1);
    e2p_req = 1'h0;
    digital_reset = 1'h1;
    step(1);
    digital_reset = 1'h0;
    step(3);
    chk("loader override", exp_of(v));
  endtask : t_loader
  // Software write wins, then a digital reset reverts to the latch without resampling new pin levels.
  // The mode field is not in the write image, so it keeps the value of the straps in force.
  task automatic t_write_revert(input logic [3:0] latched, input logic [3:0] in_force);
    logic [9:0] e;
    e = exp_of(in_force);
    sw_data = 8'h5A;
    sw_write = 1'h1;
    step(1);
    sw_write = 1'h0;
    chk("software write", {4'h5, e[5:3], 3'h5});
    // Driven pins now differ from the latch, so any resampling would show.
    level = ~latched;
    digital_reset = 1'h1;
    step(1);
    digital_reset = 1'h0;
    step(3);
    chk("revert to latched", exp_of(latched));
  endtask : t_write_revert
  initial
  begin
    step(10);
    rst = 1'h0;
    chk("reset defaults", exp_of(STRAP_RESET_VALUE));
    t_capture();
    t_loader(4'h6);
    t_write_revert(4'hF, 4'h6);
    t_loader(4'h9);
    t_write_revert(4'hF, 4'h9);
    close_out();
  end
  // Watchdog: the sequence needs well under 300 cycles.
  initial
  begin
    #200000;
    fails++;
    close_out();
  end
endmodule : port1_link_strap_defaults_tb

`default_nettype wire
